/* File: design/ie_master.sv */
// Master end of the two-wire bus: Start, address, data bytes, Stop or restart.
// Assumes the 10 MHz system clock; the bus clock is divided down from it.
//
// Overview of operation
// - Start: SDA falls while SCL high.
// - Stop: SDA rises while SCL high.
// - Bytes shift most significant bit first.
// - Transfer opens: Start, address, direction bit.
// - Direction bit one reads, zero writes.
// - Addressed slave acknowledges; roles then complement.
// - Acknowledge is SDA held low.
// - SDA changes only while SCL low.
// - Write: slave acknowledges every byte.
// - Read: master acknowledges every received byte except the last.
// - Receiving master ends in final acknowledge slot.
// - Restart may replace Stop to keep bus.
// - Master waits while slave stretches SCL.
// - Lines only pulled low or released.
// - No new message while bus busy.
// - Mismatch on SDA loses arbitration; release SDA.
// - Loser releases SCL, waits for Stop.
// - No mismatch: transfer carries on unchanged.
// - Lower address wins; same address continues.
// - Units are eight bits plus acknowledge.
// - Sender releases SDA after eighth fall.
// - Master makes SCL; sample on rising edge.
`timescale 1ns/1ps
`default_nettype none

module ie_master #(
  parameter int QTR = ie_pkg::SCL_QTR_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Transfer command.
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [6:0] cmd_addr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_len,
  input wire logic cmd_rs,
  // Data streams.
  input wire logic [7:0] tx_data,
  output logic tx_take,
  output logic [7:0] rx_data,
  output logic rx_valid,
  // Status.
  output logic done,
  output logic nack,
  output logic arb_lost,
  output logic bus_busy,
  // Bus side.
  ie_bus_if.master bus
);

  localparam int CW = ie_pkg::CNT_W;
  localparam logic [CW-1:0] LAST = CW'(QTR - 1);

  if (QTR < 1 || QTR > 255) begin : g_bad_qtr
    $error("QTR must lie between 1 and 255 cycles");
  end

  ie_pkg::ie_mst_t st_ff;
  logic [1:0] pins_s;
  logic scl_d_ff;
  logic sda_d_ff;
  logic busy_ff;
  logic [1:0] ph_ff;
  logic [CW-1:0] cnt_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic [6:0] addr_ff;
  logic rd_ff;
  logic rs_ff;
  logic [7:0] len_ff;
  logic aph_ff;
  logic ack_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic lo_ff;
  logic cmd_ready_ff;
  logic tx_take_ff;
  logic [7:0] rx_data_ff;
  logic rx_valid_ff;
  logic done_ff;
  logic nack_ff;
  logic lost_ff;
  logic out_bit;

  ////////////////////////////////////////////////////////////////////////////////
  // Line conditioning and bus-busy tracking.

  ie_sync #(
    .W(2),
    .RST({ie_pkg::LINE_IDLE, ie_pkg::LINE_IDLE})
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({bus.scl, bus.sda}),
    .q(pins_s)
  );

  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_d_ff <= ie_pkg::LINE_IDLE;
      sda_d_ff <= ie_pkg::LINE_IDLE;
      busy_ff <= 1'b0;
      lo_ff <= 1'b0;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      lo_ff <= 1'b0;
      if (start_det) begin
        busy_ff <= 1'b1;
      end else if (stop_det) begin
        busy_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer.

  wire tick = (cnt_ff == LAST);
  wire take = cmd_valid & cmd_ready_ff;
  wire tx_role = aph_ff | ~rd_ff;
  wire [7:0] nxt_len = aph_ff ? len_ff : len_ff - 8'h01;

  always_comb begin
    if (bit_ff != ie_pkg::ACK_SLOT) begin
      out_bit = tx_role ? sh_ff[7] : 1'b1;
    end else begin
      out_bit = tx_role | (len_ff == 8'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= ie_pkg::M_IDLE;
      ph_ff <= 2'h0;
      cnt_ff <= '0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      addr_ff <= 7'h00;
      rd_ff <= 1'b0;
      rs_ff <= 1'b0;
      len_ff <= 8'h00;
      aph_ff <= 1'b0;
      ack_ff <= 1'b1;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      cmd_ready_ff <= 1'b0;
      tx_take_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      lost_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
      tx_take_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      lost_ff <= 1'b0;
      case (st_ff)
        ie_pkg::M_IDLE: begin
          scl_oe_ff <= 1'b0;
          cmd_ready_ff <= ~busy_ff & ~take;
          sda_oe_ff <= take;
          if (take) begin
            addr_ff <= cmd_addr;
            rd_ff <= cmd_rd;
            len_ff <= cmd_len;
            rs_ff <= cmd_rs;
            cnt_ff <= '0;
            ph_ff <= 2'h0;
            st_ff <= ie_pkg::M_START;
          end
        end
        ie_pkg::M_START: begin
          if (tick) begin
            cnt_ff <= '0;
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h1) begin
              scl_oe_ff <= 1'b1;
              ph_ff <= 2'h0;
              bit_ff <= 4'h0;
              aph_ff <= 1'b1;
              sh_ff <= {addr_ff, rd_ff};
              st_ff <= ie_pkg::M_BITS;
            end
          end
        end
        ie_pkg::M_BITS: begin
          case (ph_ff)
            2'h0: begin
              if (tick) begin
                sda_oe_ff <= ~out_bit;
                cnt_ff <= '0;
                ph_ff <= 2'h1;
              end
            end
            2'h1: begin
              if (tick) begin
                scl_oe_ff <= 1'b0;
                ph_ff <= 2'h2;
              end
            end
            2'h2: begin
              if (scl_s) begin
                cnt_ff <= '0;
                ph_ff <= 2'h3;
                if (bit_ff != ie_pkg::ACK_SLOT && tx_role && !sda_oe_ff && !sda_s) begin
                  sda_oe_ff <= 1'b0;
                  lost_ff <= 1'b1;
                  st_ff <= ie_pkg::M_LOST;
                end else if (bit_ff == ie_pkg::ACK_SLOT) begin
                  ack_ff <= sda_s;
                end else begin
                  sh_ff <= {sh_ff[6:0], sda_s};
                end
              end
            end
            default: begin
              if (tick) begin
                scl_oe_ff <= 1'b1;
                cnt_ff <= '0;
                ph_ff <= 2'h0;
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == ie_pkg::ACK_SLOT) begin
                  bit_ff <= 4'h0;
                  aph_ff <= 1'b0;
                  len_ff <= nxt_len;
                  if (!tx_role) begin
                    rx_data_ff <= sh_ff;
                    rx_valid_ff <= 1'b1;
                  end
                  if (tx_role && ack_ff) begin
                    nack_ff <= 1'b1;
                    st_ff <= ie_pkg::M_STOP;
                  end else if (nxt_len == 8'h00) begin
                    done_ff <= rs_ff;
                    st_ff <= rs_ff ? ie_pkg::M_HOLD : ie_pkg::M_STOP;
                  end else if (!rd_ff) begin
                    sh_ff <= tx_data;
                    tx_take_ff <= 1'b1;
                  end
                end
              end
            end
          endcase
        end
        ie_pkg::M_HOLD: begin
          sda_oe_ff <= 1'b0;
          cmd_ready_ff <= ~take;
          if (take) begin
            addr_ff <= cmd_addr;
            rd_ff <= cmd_rd;
            len_ff <= cmd_len;
            rs_ff <= cmd_rs;
            cnt_ff <= '0;
            ph_ff <= 2'h0;
            st_ff <= ie_pkg::M_RS;
          end
        end
        ie_pkg::M_RS: begin
          if (ph_ff == 2'h0 && tick) begin
            scl_oe_ff <= 1'b0;
            ph_ff <= 2'h1;
          end else if (ph_ff == 2'h1 && scl_s) begin
            cnt_ff <= '0;
            ph_ff <= 2'h2;
          end else if (ph_ff == 2'h2 && tick) begin
            sda_oe_ff <= 1'b1;
            cnt_ff <= '0;
            ph_ff <= 2'h0;
            st_ff <= ie_pkg::M_START;
          end
        end
        ie_pkg::M_STOP: begin
          if (ph_ff == 2'h0 && tick) begin
            sda_oe_ff <= 1'b1;
            cnt_ff <= '0;
            ph_ff <= 2'h1;
          end else if (ph_ff == 2'h1 && tick) begin
            scl_oe_ff <= 1'b0;
            ph_ff <= 2'h2;
          end else if (ph_ff == 2'h2 && scl_s) begin
            cnt_ff <= '0;
            ph_ff <= 2'h3;
          end else if (ph_ff == 2'h3 && tick) begin
            sda_oe_ff <= 1'b0;
            done_ff <= 1'b1;
            st_ff <= ie_pkg::M_IDLE;
          end
        end
        ie_pkg::M_LOST: begin
          scl_oe_ff <= 1'b0;
          sda_oe_ff <= 1'b0;
          if (stop_det) begin
            st_ff <= ie_pkg::M_IDLE;
          end
        end
        default: begin
          st_ff <= ie_pkg::M_IDLE;
        end
      endcase
    end
  end

  assign bus.m_scl_o = lo_ff;
  assign bus.m_sda_o = lo_ff;
  assign bus.m_scl_oe = scl_oe_ff;
  assign bus.m_sda_oe = sda_oe_ff;
  assign cmd_ready = cmd_ready_ff;
  assign tx_take = tx_take_ff;
  assign rx_data = rx_data_ff;
  assign rx_valid = rx_valid_ff;
  assign done = done_ff;
  assign nack = nack_ff;
  assign arb_lost = lost_ff;
  assign bus_busy = busy_ff;

endmodule

`default_nettype wire

/* File: design/ie_pkg.sv */
// Shared constants and state types for the two-wire bus protocol engine.
// Assumes a 10 MHz system clock on the master end.
`default_nettype none

package ie_pkg;

  // System clock and bus bit timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int CNT_W = 8;

  // Byte framing: eight data bits, then the acknowledge slot.
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Default seven-bit address of the device end.
  localparam logic [6:0] DEF_OWN_ADDR = 7'h42;

  // Reset levels of synchronised bus lines and toggles.
  localparam logic LINE_IDLE = 1'b1;
  localparam logic TGL_RST = 1'b0;

  typedef enum logic [2:0] {
    M_IDLE,
    M_START,
    M_BITS,
    M_HOLD,
    M_RS,
    M_STOP,
    M_LOST
  } ie_mst_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RECV,
    S_ACK,
    S_FETCH,
    S_SEND,
    S_MACK
  } ie_slv_t;

endpackage

`default_nettype wire

/* File: design/ie_bus_if.sv */
// Shared two-wire open-drain bus joining the master end and the device end.
// Assumes the bench drives ext_scl_low and ext_sda_low for other participants.
`timescale 1ns/1ps
`default_nettype none

interface ie_bus_if;

  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_scl_o;
  logic s_scl_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic ext_scl_low;
  logic ext_sda_low;
  logic scl;
  logic sda;

  // Wired-AND with pull-up: a line is low if any party pulls it low.
  assign scl = ~((m_scl_oe & ~m_scl_o) | (s_scl_oe & ~s_scl_o) | ext_scl_low);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o) | ext_sda_low);

  modport master (
    input scl,
    input sda,
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe
  );

  modport device (
    input scl,
    input sda,
    output s_scl_o,
    output s_scl_oe,
    output s_sda_o,
    output s_sda_oe
  );

endinterface

`default_nettype wire

/* File: design/ie_sync.sv */
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a level or toggle that may change at any time.
`timescale 1ns/1ps
`default_nettype none

module ie_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Levels.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= RST;
      q_ff <= RST;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule

`default_nettype wire

/* File: design/ie_slave.sv */
// Device end: addressed slave on the two-wire bus, receive and transmit.
// Assumes link_clk is far faster than the bus clock and free-running.
`timescale 1ns/1ps
`default_nettype none

module ie_slave #(
  parameter logic [6:0] OWN_ADDR = ie_pkg::DEF_OWN_ADDR
) (
  // Link clock domain.
  input wire logic link_clk,
  input wire logic link_rst_n,
  // User clock domain.
  input wire logic clk,
  input wire logic rst_n,
  // User data.
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_req,
  input wire logic [7:0] tx_data,
  input wire logic tx_ack,
  // Bus side.
  ie_bus_if.device bus
);

  ie_pkg::ie_slv_t st_ff;
  logic [2:0] lq;
  logic scl_d_ff;
  logic sda_d_ff;
  logic ack_d_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic aph_ff;
  logic rw_ff;
  logic mack_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic lo_ff;
  logic [7:0] rx_buf_ff;
  logic rx_tgl_ff;
  logic req_tgl_ff;
  logic [1:0] uq;
  logic req_d_ff;
  logic rx_d_ff;
  logic tx_req_ff;
  logic rx_valid_ff;
  logic [7:0] rx_data_ff;
  logic [7:0] tx_buf_ff;
  logic ack_tgl_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: line conditioning and condition detection.

  ie_sync #(
    .W(3),
    .RST({ie_pkg::LINE_IDLE, ie_pkg::LINE_IDLE, ie_pkg::TGL_RST})
  ) u_lsync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({bus.scl, bus.sda, ack_tgl_ff}),
    .q(lq)
  );

  wire scl_s = lq[2];
  wire sda_s = lq[1];
  wire rise = scl_s & ~scl_d_ff;
  wire fall = ~scl_s & scl_d_ff;
  wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire ack_ev = lq[0] ^ ack_d_ff;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      scl_d_ff <= ie_pkg::LINE_IDLE;
      sda_d_ff <= ie_pkg::LINE_IDLE;
      ack_d_ff <= ie_pkg::TGL_RST;
      lo_ff <= 1'b0;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      ack_d_ff <= lq[0];
      lo_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: byte engine.

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      st_ff <= ie_pkg::S_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      aph_ff <= 1'b0;
      rw_ff <= 1'b0;
      mack_ff <= 1'b1;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      rx_buf_ff <= 8'h00;
      rx_tgl_ff <= ie_pkg::TGL_RST;
      req_tgl_ff <= ie_pkg::TGL_RST;
    end else if (start_det) begin
      st_ff <= ie_pkg::S_RECV;
      bit_ff <= 4'h0;
      aph_ff <= 1'b1;
      rw_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (stop_det) begin
      st_ff <= ie_pkg::S_IDLE;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      case (st_ff)
        ie_pkg::S_RECV: begin
          if (rise) begin
            sh_ff <= {sh_ff[6:0], sda_s};
            bit_ff <= bit_ff + 4'h1;
          end
          if (fall && bit_ff == ie_pkg::ACK_SLOT) begin
            bit_ff <= 4'h0;
            if (!aph_ff) begin
              rx_buf_ff <= sh_ff;
              rx_tgl_ff <= ~rx_tgl_ff;
              sda_oe_ff <= 1'b1;
              st_ff <= ie_pkg::S_ACK;
            end else if (sh_ff[7:1] == OWN_ADDR) begin
              rw_ff <= sh_ff[0];
              sda_oe_ff <= 1'b1;
              st_ff <= ie_pkg::S_ACK;
            end else begin
              st_ff <= ie_pkg::S_IDLE;
            end
          end
        end
        ie_pkg::S_ACK: begin
          if (fall) begin
            sda_oe_ff <= 1'b0;
            aph_ff <= 1'b0;
            if (rw_ff) begin
              req_tgl_ff <= ~req_tgl_ff;
              scl_oe_ff <= 1'b1;
              st_ff <= ie_pkg::S_FETCH;
            end else begin
              st_ff <= ie_pkg::S_RECV;
            end
          end
        end
        ie_pkg::S_FETCH: begin
          if (ack_ev) begin
            sh_ff <= tx_buf_ff;
            sda_oe_ff <= ~tx_buf_ff[7];
            bit_ff <= 4'h0;
            st_ff <= ie_pkg::S_SEND;
          end
        end
        ie_pkg::S_SEND: begin
          // The clock is let go one cycle after the first bit is set up.
          scl_oe_ff <= 1'b0;
          if (rise) begin
            bit_ff <= bit_ff + 4'h1;
            if (!sda_oe_ff && !sda_s) begin
              st_ff <= ie_pkg::S_IDLE;
            end
          end
          if (fall) begin
            if (bit_ff == ie_pkg::ACK_SLOT) begin
              sda_oe_ff <= 1'b0;
              st_ff <= ie_pkg::S_MACK;
            end else begin
              sh_ff <= {sh_ff[6:0], 1'b0};
              sda_oe_ff <= ~sh_ff[6];
            end
          end
        end
        ie_pkg::S_MACK: begin
          if (rise) begin
            mack_ff <= sda_s;
          end
          if (fall) begin
            bit_ff <= 4'h0;
            if (!mack_ff) begin
              req_tgl_ff <= ~req_tgl_ff;
              scl_oe_ff <= 1'b1;
              st_ff <= ie_pkg::S_FETCH;
            end else begin
              st_ff <= ie_pkg::S_IDLE;
            end
          end
        end
        default: begin
          scl_oe_ff <= 1'b0;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  assign bus.s_scl_o = lo_ff;
  assign bus.s_sda_o = lo_ff;
  assign bus.s_scl_oe = scl_oe_ff;
  assign bus.s_sda_oe = sda_oe_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // User domain: byte hand-over by toggles; words are stable before the toggle.

  ie_sync #(
    .W(2),
    .RST({ie_pkg::TGL_RST, ie_pkg::TGL_RST})
  ) u_usync (
    .clk(clk),
    .rst_n(rst_n),
    .d({req_tgl_ff, rx_tgl_ff}),
    .q(uq)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_d_ff <= ie_pkg::TGL_RST;
      rx_d_ff <= ie_pkg::TGL_RST;
      tx_req_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      tx_buf_ff <= 8'h00;
      ack_tgl_ff <= ie_pkg::TGL_RST;
    end else begin
      req_d_ff <= uq[1];
      rx_d_ff <= uq[0];
      tx_req_ff <= uq[1] ^ req_d_ff;
      rx_valid_ff <= uq[0] ^ rx_d_ff;
      if (uq[0] ^ rx_d_ff) begin
        rx_data_ff <= rx_buf_ff;
      end
      if (tx_ack) begin
        tx_buf_ff <= tx_data;
        ack_tgl_ff <= ~ack_tgl_ff;
      end
    end
  end

  assign tx_req = tx_req_ff;
  assign rx_valid = rx_valid_ff;
  assign rx_data = rx_data_ff;

endmodule

`default_nettype wire

/* File: tb/ie_bus_assertions.sv */
// Checker for the shared two-wire bus between the master and device ends.
// Assumes the bench instantiates it beside the bus and connects by name.
`timescale 1ns/1ps
`default_nettype none

module ie_bus_assertions (
  // Clocks and resets.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_rst_n,
  // Bus signals.
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_scl_o,
  input wire logic s_scl_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic ext_scl_low,
  input wire logic ext_sda_low,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_ff;
  logic sda_q_ff;
  logic [3:0] bit_ff;

  always_ff @(posedge clk) begin
    scl_q_ff <= scl;
    sda_q_ff <= sda;
  end

  // Bit position within the nine-bit unit, restarted by each Start.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_ff <= 4'h0;
    end else if (scl && scl_q_ff && sda_q_ff && !sda) begin
      bit_ff <= 4'h0;
    end else if (scl && !scl_q_ff) begin
      bit_ff <= (bit_ff == 4'h9) ? 4'h1 : bit_ff + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_pins_only_low: assert property (@(posedge clk) disable iff (!rst_n)
    !m_scl_o && !m_sda_o && !s_scl_o && !s_sda_o) else $error("bus pin driven high");
  a_slave_data_low: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $changed(s_sda_oe) |-> !scl) else $error("device changed data with clock high");
  a_data_stable_high: assert property (@(posedge clk) disable iff (!rst_n)
    (scl && scl_q_ff && bit_ff >= 4'h2 && !ext_sda_low && !$past(ext_sda_low))
    |-> sda == sda_q_ff) else $error("data moved inside a bit");
  a_ack_one_driver: assert property (@(posedge clk) disable iff (!rst_n)
    (scl && !scl_q_ff && bit_ff == 4'h8 && !sda) |-> (m_sda_oe ^ s_sda_oe))
    else $error("acknowledge slot driven by both or none");
  a_loser_releases: assert property (@(posedge clk) disable iff (!rst_n)
    (scl && !scl_q_ff && ext_sda_low && !m_sda_oe && !s_sda_oe)
    |-> ##4 (!m_scl_oe && !m_sda_oe)) else $error("master kept driving after loss");
  a_stretch_wait: assert property (@(posedge clk) disable iff (!rst_n)
    (!m_scl_oe && !scl) |=> (!m_scl_oe && $stable(m_sda_oe)))
    else $error("master moved while clock stretched");
  a_start_form: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(m_sda_oe) && scl) |-> (sda_q_ff && !m_scl_oe)) else $error("bad start");
  a_stop_release: assert property (@(posedge clk) disable iff (!rst_n)
    ($fell(m_sda_oe) && scl) |-> (!m_scl_oe) [*4]) else $error("clock pulled after stop");
endmodule

`default_nettype wire

/* File: tb/i2c_bus_protocol_engine_tb_top.sv */
// Bench joining master and device ends over the bus, with a stand-in third party.
// Assumes the design files under design/ are compiled first.
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_protocol_engine_tb_top;
  localparam int QTR = 4;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_rd = 1'b0;
  logic cmd_rs = 1'b0;
  logic s_tx_ack = 1'b0;
  logic ext_scl_low = 1'b0;
  logic ext_sda_low = 1'b0;
  logic [6:0] cmd_addr = 7'h0;
  logic [7:0] cmd_len = 8'h0;
  logic [7:0] s_tx_data = 8'h0;
  logic cmd_ready, m_tx_take, m_rx_valid, done, nack, arb_lost, bus_busy, s_rx_valid, s_tx_req;
  logic [7:0] m_tx_data, m_rx_data, s_rx_data, sh, addr_seen;
  logic [7:0] mtx [4];
  logic [7:0] stx [4];
  logic [7:0] mrx [4];
  logic [7:0] srx [4];
  int mi, mr, sr, si, nb, fails, checks_done;

  always #50 clk = ~clk;
  initial #3.3 forever #6 link_clk = ~link_clk;

  ie_bus_if bus ();
  assign bus.ext_scl_low = ext_scl_low;
  assign bus.ext_sda_low = ext_sda_low;

  ie_master #(.QTR(QTR)) u_ie_master (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_rd(cmd_rd), .cmd_len(cmd_len),
    .cmd_rs(cmd_rs), .tx_data(m_tx_data), .tx_take(m_tx_take), .rx_data(m_rx_data),
    .rx_valid(m_rx_valid), .done(done), .nack(nack), .arb_lost(arb_lost),
    .bus_busy(bus_busy), .bus(bus.master));
  ie_slave u_ie_slave (.link_clk(link_clk), .link_rst_n(rst_n), .clk(clk), .rst_n(rst_n),
    .rx_data(s_rx_data), .rx_valid(s_rx_valid), .tx_req(s_tx_req), .tx_data(s_tx_data),
    .tx_ack(s_tx_ack), .bus(bus.device));
  ie_bus_assertions u_ie_bus_assertions (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
    .link_rst_n(rst_n), .m_scl_o(bus.m_scl_o), .m_scl_oe(bus.m_scl_oe),
    .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe), .s_scl_o(bus.s_scl_o),
    .s_scl_oe(bus.s_scl_oe), .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe),
    .ext_scl_low(ext_scl_low), .ext_sda_low(ext_sda_low), .scl(bus.scl), .sda(bus.sda));

  ////////////////////////////////////////////////////////////////////////////
  // Bits seen on the wire at each clock rise, counted from the last Start.
  always @(negedge bus.sda) if (bus.scl) nb = 0;
  always @(posedge bus.scl) begin
    sh = {sh[6:0], bus.sda};
    nb = nb + 1;
    if (nb == 8) addr_seen = sh;
  end

  assign m_tx_data = mtx[mi[1:0]];
  always @(posedge clk) begin
    if (m_tx_take === 1'b1) mi <= mi + 1;
    if (m_rx_valid === 1'b1) begin
      mrx[mr[1:0]] <= m_rx_data;
      mr <= mr + 1;
    end
    if (s_rx_valid === 1'b1) begin
      srx[sr[1:0]] <= s_rx_data;
      sr <= sr + 1;
    end
  end

  // Device user answers each request late, so the device must stretch the clock.
  initial begin
    forever begin
      @(posedge clk);
      if (s_tx_req === 1'b1) begin
        repeat (20) @(negedge clk);
        s_tx_data = stx[si[1:0]];
        s_tx_ack = 1'b1;
        @(negedge clk);
        s_tx_ack = 1'b0;
        si = si + 1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic timeout;
    fails = fails + 1;
    final_report();
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic run(input logic [6:0] a, input logic rd, input logic [7:0] len,
                     input logic rs, output logic [1:0] ev);
    int i;
    @(negedge clk);
    mi = 0;
    mr = 0;
    sr = 0;
    si = 0;
    {cmd_addr, cmd_rd, cmd_len, cmd_rs} = {a, rd, len, rs};
    cmd_valid = 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i = i + 1;
    end while (cmd_ready !== 1'b1 && i < 2000);
    @(negedge clk);
    cmd_valid = 1'b0;
    if (i >= 2000) timeout();
    ev = 2'h0;
    for (i = 0; i < 20000 && ev == 2'h0; i++) begin
      @(negedge clk);
      if (arb_lost === 1'b1) ev = 2'h3;
      else if (nack === 1'b1) ev = 2'h2;
      else if (done === 1'b1) ev = 2'h1;
    end
    if (ev == 2'h0) timeout();
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 2000 && bus_busy !== 1'b0; i++) @(negedge clk);
    if (i >= 2000) timeout();
  endtask

  // Another party pulls data low from the first clock-low phase of the address.
  task automatic pull_first_bit(input logic hold_long);
    int i;
    for (i = 0; i < 500 && bus.m_scl_oe !== 1'b1; i++) @(negedge clk);
    ext_sda_low = 1'b1;
    if (hold_long) begin
      repeat (40) @(negedge clk);
    end else begin
      for (i = 0; i < 500 && bus.m_scl_oe !== 1'b0; i++) @(negedge clk);
      for (i = 0; i < 500 && bus.m_scl_oe !== 1'b1; i++) @(negedge clk);
    end
    ext_sda_low = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_write;
    logic [1:0] ev;
    mtx[0] = 8'ha5;
    mtx[1] = 8'h3c;
    run(7'h42, 1'b0, 8'h02, 1'b0, ev);
    wait_idle();
    chk({6'h0, ev}, 8'h01);
    chk(addr_seen, 8'h84);
    chk(nb[7:0], 8'h1c);
    chk(srx[0], 8'ha5);
    chk(srx[1], 8'h3c);
    chk(sr[7:0], 8'h02);
  endtask

  task automatic s_rs_read;
    logic [1:0] ev;
    mtx[0] = 8'h96;
    run(7'h42, 1'b0, 8'h01, 1'b1, ev);
    chk({6'h0, ev}, 8'h01);
    chk({7'h0, bus_busy}, 8'h01);
    chk(srx[0], 8'h96);
    stx[0] = 8'hc3;
    stx[1] = 8'h5a;
    run(7'h42, 1'b1, 8'h02, 1'b0, ev);
    wait_idle();
    chk({6'h0, ev}, 8'h01);
    chk(addr_seen, 8'h85);
    chk(mrx[0], 8'hc3);
    chk(mrx[1], 8'h5a);
    chk(nb[7:0], 8'h1c);
    chk(si[7:0], 8'h02);
  endtask

  task automatic s_nack_same_level;
    logic [1:0] ev;
    fork
      run(7'h13, 1'b0, 8'h01, 1'b0, ev);
      pull_first_bit(1'b0);
    join
    wait_idle();
    chk({6'h0, ev}, 8'h02);
    chk(sr[7:0], 8'h00);
    chk(nb[7:0], 8'h0a);
  endtask

  task automatic s_busy;
    logic [1:0] ev;
    @(negedge clk);
    ext_sda_low = 1'b1;
    repeat (5) @(negedge clk);
    fork
      run(7'h42, 1'b0, 8'h00, 1'b0, ev);
      begin
        repeat (30) @(negedge clk);
        chk({7'h0, bus_busy}, 8'h01);
        chk({6'h0, cmd_ready, bus.m_scl_oe}, 8'h00);
        ext_scl_low = 1'b1;
        repeat (5) @(negedge clk);
        ext_scl_low = 1'b0;
        repeat (5) @(negedge clk);
        ext_sda_low = 1'b0;
      end
    join
    wait_idle();
    chk({6'h0, ev}, 8'h01);
  endtask

  task automatic s_arb;
    logic [1:0] ev;
    fork
      run(7'h42, 1'b0, 8'h01, 1'b0, ev);
      pull_first_bit(1'b1);
    join
    wait_idle();
    chk({6'h0, ev}, 8'h03);
    chk({6'h0, bus.m_scl_oe, bus.m_sda_oe}, 8'h00);
  endtask

  initial begin
    fails = 0;
    checks_done = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    s_write();
    s_rs_read();
    s_nack_same_level();
    s_busy();
    s_arb();
    final_report();
  end
endmodule

`default_nettype wire
